// >>> core/amrs_regs.svh
// register offsets, field positions and reset values of the read sequencer
`ifndef AMRS_REGS_SVH
`define AMRS_REGS_SVH
`define AMRS_OFF_CTRL 12'h000
`define AMRS_OFF_TIMING 12'h004
`define AMRS_OFF_ADDR 12'h008
`define AMRS_OFF_CMD 12'h00C
`define AMRS_OFF_STATUS 12'h010
`define AMRS_OFF_RDATA 12'h014
`define AMRS_MODE_ASYNC 2'h0
`define AMRS_CLKOUT_BUS 2'h3
`define AMRS_CTRL_RESET 5'h00
`define AMRS_TIMING_RESET 20'h11111
`define AMRS_CMD_START_BIT 8
`define AMRS_ST_BUSY_BIT 0
`define AMRS_ST_DONE_BIT 1
`define AMRS_ST_REFUSED_BIT 2
`define AMRS_CNT_ONE 4'h1
`define AMRS_CNT_ZERO 4'h0
`define AMRS_SYNC_LAT 2
`endif

// >>> core/amrs_pkg.sv
// shared types of the asynchronous memory read sequencer
package amrs_pkg;
    // software control fields
    typedef struct packed {
        logic [1:0] clock_output_select;
        logic ready_wait_enable;
        logic [1:0] bank_mode;
    } amrs_ctrl_s;
    // phase lengths in bus clock cycles
    typedef struct packed {
        logic [3:0] hold_cycles;
        logic [3:0] access_cycles;
        logic [3:0] post_strobe_cycles;
        logic [3:0] valid_strobe_cycles;
        logic [3:0] setup_cycles;
    } amrs_timing_s;
    // read cycle phases, one-hot
    typedef enum logic [5:0] {
        AMRS_IDLE = 6'b000001,
        AMRS_SETUP = 6'b000010,
        AMRS_STROBE = 6'b000100,
        AMRS_POST = 6'b001000,
        AMRS_ACCESS = 6'b010000,
        AMRS_HOLD = 6'b100000
    } amrs_phase_e;
endpackage

// >>> core/amrs_clkout.sv
// clock output pin: buffered bus clock when the select field asks for it
`timescale 1ns/1ps
`default_nettype none
`include "amrs_regs.svh"
module amrs_clkout (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [1:0] clock_output_select,
    output logic clock_output_pin
);
    import amrs_pkg::*;
    logic enable; // registered select match, changes only while clock is low at the pin

    // select is retimed so the gate never chops a high phase mid-way
    always_ff @(negedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            enable <= 1'b0;
        end else begin
            enable <= (clock_output_select == `AMRS_CLKOUT_BUS);
        end
    end

    // gated copy of the bus clock
    assign clock_output_pin = sys_clk & enable;
endmodule
`default_nettype wire

// >>> core/amrs_seq.sv
// asynchronous memory read sequencer with apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "amrs_regs.svh"
module amrs_seq #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16,
    parameter int BANKS = 4,
    parameter int BE_W = 2
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic ready_input,
    output logic [ADDR_W-1:0] address_bus,
    output logic [BANKS-1:0] bank_select_n,
    output logic [BE_W-1:0] byte_enable_n,
    output logic output_enable_n,
    output logic read_strobe_n,
    output logic address_valid_strobe_n,
    output logic clock_output_pin
);
    import amrs_pkg::*;

    // parameters the register layout can hold
    initial begin
        if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 1 || DATA_W > 32 || BANKS < 1
            || BANKS > 4 || BE_W < 1 || BE_W > 4) begin
            $error("amrs_seq: parameter out of range");
        end
    end

    // software state
    amrs_ctrl_s ctrl; // mode, ready wait, clock select
    amrs_timing_s timing; // phase lengths
    logic [ADDR_W-1:0] addr_reg; // address of next read
    logic [DATA_W-1:0] rdata_reg; // last captured data
    logic done; // sticky: a read finished
    logic refused; // sticky: a start was refused

    // sequencer state
    amrs_phase_e phase, next_phase; // current and next phase
    logic [3:0] cnt; // cycles left in the phase
    logic [3:0] next_cnt; // load value for the next cycle
    logic [1:0] bank_reg; // latched bank index
    logic [BE_W-1:0] be_reg; // latched byte enables
    logic [DATA_W-1:0] data_s1, data_s2; // data pin synchroniser
    logic ready_s1, ready_s2; // ready pin synchroniser
    logic [`AMRS_SYNC_LAT-1:0] cap_pipe; // delays capture to match data sync
    logic capture_busy; // capture still pending

    // apb decode
    wire wr_en = psel & penable & pwrite & pready;
    wire rd_setup = psel & ~penable;
    wire hit_ctrl = (paddr == `AMRS_OFF_CTRL);
    wire hit_timing = (paddr == `AMRS_OFF_TIMING);
    wire hit_addr = (paddr == `AMRS_OFF_ADDR);
    wire hit_cmd = (paddr == `AMRS_OFF_CMD);
    wire hit_status = (paddr == `AMRS_OFF_STATUS);
    wire hit_rdata = (paddr == `AMRS_OFF_RDATA);
    wire hit_any = hit_ctrl | hit_timing | hit_addr | hit_cmd | hit_status | hit_rdata;
    wire busy = (phase != AMRS_IDLE) | capture_busy;
    wire start_req = wr_en & hit_cmd & pwdata[`AMRS_CMD_START_BIT];
    wire mode_ok = (ctrl.bank_mode == `AMRS_MODE_ASYNC);
    wire start_ok = start_req & ~busy & mode_ok;
    wire start_bad = start_req & ~start_ok;
    wire cnt_last = (cnt <= `AMRS_CNT_ONE);
    wire access_end = cnt_last & (~ctrl.ready_wait_enable | ready_s2);
    wire capture_now = (phase == AMRS_ACCESS) & (next_phase != AMRS_ACCESS);

    // read mux
    wire [31:0] status_word = {29'h0, refused, done, busy};
    wire [31:0] rd_word =
        hit_ctrl ? {27'h0, ctrl} :
        hit_timing ? {12'h0, timing} :
        hit_addr ? 32'(addr_reg) :
        hit_status ? status_word :
        hit_rdata ? 32'(rdata_reg) : 32'h0;

    // phase lengths below one are stretched to one cycle
    function automatic logic [3:0] amrs_len(input logic [3:0] f);
        amrs_len = (f == `AMRS_CNT_ZERO) ? `AMRS_CNT_ONE : f;
    endfunction

    // next phase and its count, in fixed order
    always_comb begin
        next_phase = phase;
        next_cnt = cnt - `AMRS_CNT_ONE;
        unique case (phase)
            AMRS_IDLE: begin
                next_cnt = cnt;
                if (start_ok) begin
                    next_phase = AMRS_SETUP;
                    next_cnt = amrs_len(timing.setup_cycles);
                end
            end
            AMRS_SETUP: begin
                if (cnt_last) begin
                    next_phase = AMRS_STROBE;
                    next_cnt = amrs_len(timing.valid_strobe_cycles);
                end
            end
            AMRS_STROBE: begin
                if (cnt_last) begin
                    next_phase = AMRS_POST;
                    next_cnt = amrs_len(timing.post_strobe_cycles);
                end
            end
            AMRS_POST: begin
                if (cnt_last) begin
                    next_phase = AMRS_ACCESS;
                    next_cnt = amrs_len(timing.access_cycles);
                end
            end
            AMRS_ACCESS: begin
                if (cnt_last) begin
                    next_cnt = `AMRS_CNT_ONE; // waiting on ready keeps count at end
                end
                if (access_end) begin
                    next_phase = AMRS_HOLD;
                    next_cnt = amrs_len(timing.hold_cycles);
                end
            end
            AMRS_HOLD: begin
                if (cnt_last) begin
                    next_phase = AMRS_IDLE;
                    next_cnt = `AMRS_CNT_ZERO;
                end
            end
            default: begin
                next_phase = AMRS_IDLE;
                next_cnt = `AMRS_CNT_ZERO;
            end
        endcase
    end

    // pin synchronisers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ready_s1 <= 1'b0;
            ready_s2 <= 1'b0;
            data_s1 <= '0;
            data_s2 <= '0;
        end else begin
            ready_s1 <= ready_input;
            ready_s2 <= ready_s1;
            data_s1 <= data_in;
            data_s2 <= data_s1;
        end
    end

    // phase register and latched request
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase <= AMRS_IDLE;
            cnt <= `AMRS_CNT_ZERO;
            bank_reg <= 2'h0;
            be_reg <= '0;
        end else begin
            phase <= next_phase;
            cnt <= next_cnt;
            if (start_ok) begin
                bank_reg <= pwdata[1:0];
                be_reg <= pwdata[4+:BE_W];
            end
        end
    end

    // memory pins registered from the next phase, so they follow it exactly
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            address_bus <= '0;
            bank_select_n <= '1;
            byte_enable_n <= '1;
            output_enable_n <= 1'b1;
            read_strobe_n <= 1'b1;
            address_valid_strobe_n <= 1'b1;
        end else begin
            if (start_ok) begin
                address_bus <= addr_reg;
            end
            bank_select_n <= (next_phase == AMRS_IDLE) ? '1 :
                ~(BANKS'(1) << (start_ok ? pwdata[1:0] : bank_reg));
            byte_enable_n <= (next_phase == AMRS_IDLE) ? '1 :
                ~(start_ok ? pwdata[4+:BE_W] : be_reg);
            output_enable_n <= ~((next_phase == AMRS_STROBE) | (next_phase == AMRS_POST)
                | (next_phase == AMRS_ACCESS) | (next_phase == AMRS_HOLD));
            read_strobe_n <= (next_phase != AMRS_ACCESS);
            address_valid_strobe_n <= (next_phase != AMRS_STROBE);
        end
    end

    // data capture: pin value at the strobe rising edge leaves the synchroniser two cycles on
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cap_pipe <= '0;
            rdata_reg <= '0;
        end else begin
            cap_pipe <= {cap_pipe[`AMRS_SYNC_LAT-2:0], capture_now};
            if (cap_pipe[`AMRS_SYNC_LAT-1]) begin
                rdata_reg <= data_s2;
            end
        end
    end
    assign capture_busy = |cap_pipe;

    // software registers; hardware set of a flag wins over its clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `AMRS_CTRL_RESET;
            timing <= `AMRS_TIMING_RESET;
            addr_reg <= '0;
            done <= 1'b0;
            refused <= 1'b0;
        end else begin
            if (wr_en & hit_ctrl) begin
                ctrl <= pwdata[4:0];
            end
            if (wr_en & hit_timing & ~busy) begin
                timing <= pwdata[19:0];
            end
            if (wr_en & hit_addr & ~busy) begin
                addr_reg <= pwdata[ADDR_W-1:0];
            end
            if (cap_pipe[`AMRS_SYNC_LAT-1]) begin
                done <= 1'b1;
            end else if (wr_en & hit_status & pwdata[`AMRS_ST_DONE_BIT]) begin
                done <= 1'b0;
            end
            if (start_bad) begin
                refused <= 1'b1;
            end else if (wr_en & hit_status & pwdata[`AMRS_ST_REFUSED_BIT]) begin
                refused <= 1'b0;
            end
        end
    end

    // apb answer: ready in the first access cycle, error on unmapped address
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= rd_setup;
            pslverr <= rd_setup & ~hit_any;
            prdata <= (rd_setup & ~pwrite) ? rd_word : 32'h0;
        end
    end

    // clock output pin
    amrs_clkout u_clkout (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clock_output_select(ctrl.clock_output_select),
        .clock_output_pin(clock_output_pin)
    );
endmodule
`default_nettype wire

// >>> verif/amrs_mem_model.sv
// behavioural asynchronous memory facing the read sequencer
`timescale 1ns/1ps
`default_nettype none
module amrs_mem_model #(parameter int ADDR_W = 24, parameter int DATA_W = 16) (
    input wire logic sys_clk,
    input wire logic [ADDR_W-1:0] address_bus,
    input wire logic [3:0] bank_select_n,
    input wire logic output_enable_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] ready_delay,
    output logic [DATA_W-1:0] data_in,
    output logic ready_input
);
    logic [7:0] low_cnt = 8'h00; // cycles since the strobe fell
    logic [DATA_W-1:0] junk = '0; // changes every cycle while released
    wire logic drive = ~&bank_select_n & ~output_enable_n; // selected and read
    // count the access and scramble the released bus
    always @(posedge sys_clk) begin
        low_cnt <= read_strobe_n ? 8'h00 : low_cnt + 8'h01;
        junk <= ~junk;
    end
    // data valid while driven, up to and past the strobe rising
    assign data_in = drive ? address_bus[DATA_W-1:0] ^ 16'hA5C3 : junk;
    // ready low at once in the access, high after the chosen delay
    assign ready_input = ~read_strobe_n && (low_cnt >= ready_delay);
endmodule
`default_nettype wire

// >>> verif/amrs_seq_properties.sv
// pin and bus timing checker bound to the read sequencer
`timescale 1ns/1ps
`default_nettype none
module amrs_seq_properties #(parameter int ADDR_W = 24, parameter int BANKS = 4) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [ADDR_W-1:0] address_bus,
    input wire logic [BANKS-1:0] bank_select_n,
    input wire logic output_enable_n,
    input wire logic read_strobe_n,
    input wire logic address_valid_strobe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire logic bank_on = ~&bank_select_n; // some bank selected
    // post wait then strobe fall, post field at most 15
    sequence s_post_then_read;
        read_strobe_n ##[1:16] $fell(read_strobe_n);
    endsequence
    // hold phase: selects still asserted after the strobe rises
    sequence s_hold;
        bank_on && !output_enable_n && $stable(address_bus);
    endsequence
    a_apb_one_wait: assert property (psel && !penable |=> pready)
        else $error("ready late");
    a_bank_before_avs: assert property ($fell(address_valid_strobe_n) |-> $past(bank_on))
        else $error("bank late");
    a_avs_in_bank: assert property (!address_valid_strobe_n |-> bank_on && !output_enable_n)
        else $error("strobe outside bank");
    a_post_gap: assert property ($rose(address_valid_strobe_n) |-> s_post_then_read)
        else $error("post wait");
    a_oe_lead: assert property ($fell(read_strobe_n) |-> !$past(output_enable_n, 2))
        else $error("oe lead");
    a_addr_steady: assert property (!read_strobe_n |-> bank_on && $stable(address_bus))
        else $error("address moved");
    a_hold_after: assert property ($rose(read_strobe_n) |-> s_hold)
        else $error("hold short");
    a_one_bank: assert property ($onehot0(~bank_select_n))
        else $error("two banks");
    a_phase_excl: assert property (!(!read_strobe_n && !address_valid_strobe_n))
        else $error("phases overlap");
endmodule
bind amrs_seq amrs_seq_properties #(.ADDR_W(ADDR_W), .BANKS(BANKS)) i_props (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pready(pready),
    .address_bus(address_bus), .bank_select_n(bank_select_n),
    .output_enable_n(output_enable_n), .read_strobe_n(read_strobe_n),
    .address_valid_strobe_n(address_valid_strobe_n));
`default_nettype wire

// >>> verif/amrs_seq_test.sv
// self-checking bench for the asynchronous memory read sequencer
`timescale 1ns/1ps
`default_nettype none
`include "amrs_regs.svh"
module amrs_seq_test;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q, tim;
    logic pready, pslverr, slv_q, ready_input, oe_n, re_n, avs_n, clk_pin;
    logic [15:0] data_in;
    logic [23:0] address_bus;
    logic [3:0] bank_n, bs_q;
    logic [1:0] be_n, be_q;
    logic [7:0] ready_delay = 8'h64; // ready never comes by default
    int n_errors = 0, cmp_count = 0, cyc = 0, k;
    int t [8]; // cycle stamps of pin events
    amrs_seq i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_in(data_in), .ready_input(ready_input),
        .address_bus(address_bus), .bank_select_n(bank_n), .byte_enable_n(be_n),
        .output_enable_n(oe_n), .read_strobe_n(re_n), .address_valid_strobe_n(avs_n),
        .clock_output_pin(clk_pin));
    amrs_mem_model i_mem (.sys_clk(sys_clk), .address_bus(address_bus),
        .bank_select_n(bank_n), .output_enable_n(oe_n), .read_strobe_n(re_n),
        .ready_delay(ready_delay), .data_in(data_in), .ready_input(ready_input));
    initial forever #2.5 sys_clk = ~sys_clk;
    // stamp every strobe edge with the cycle number
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if ($fell(&bank_n)) t[0] <= cyc;
        if ($fell(avs_n)) t[1] <= cyc;
        if ($rose(avs_n)) t[2] <= cyc;
        if ($rose(re_n)) t[4] <= cyc;
        if ($rose(&bank_n)) t[5] <= cyc;
        if ($fell(oe_n)) t[6] <= cyc;
        if ($rose(ready_input)) t[7] <= cyc;
        if ($fell(re_n)) begin
            t[3] <= cyc;
            bs_q <= bank_n;
            be_q <= be_n;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, s, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one apb transfer; result left in rd_q and slv_q
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
            $display("[ERR] %0t apb transfer never answered", $time);
            stop_test();
        end
        rd_q = prdata;
        slv_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // start a read of bank 2, low byte only, and check the data
    task automatic rd_cycle(input logic [23:0] ad);
        apb(1'b1, `AMRS_OFF_TIMING, tim);
        apb(1'b1, `AMRS_OFF_ADDR, {8'h0, ad});
        apb(1'b1, `AMRS_OFF_CMD, 32'h112);
        // a write returns no data, so busy is fetched before the poll looks at it
        apb(1'b0, `AMRS_OFF_STATUS, 32'h0);
        for (k = 0; k < 40 && rd_q[`AMRS_ST_BUSY_BIT] !== 1'b0; k++) begin
            apb(1'b0, `AMRS_OFF_STATUS, 32'h0);
        end
        if (k >= 40) begin
            n_errors++;
            $display("[ERR] %0t read cycle never finished", $time);
            stop_test();
        end
        chk(rd_q & 32'h3, 32'h2, "done");
        apb(1'b1, `AMRS_OFF_STATUS, 32'h2);
        apb(1'b0, `AMRS_OFF_RDATA, 32'h0);
        chk(rd_q, {16'h0, ad[15:0] ^ 16'hA5C3}, "data");
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        apb(1'b0, `AMRS_OFF_CTRL, 32'h0);
        chk(rd_q, 32'h0, "ctrl reset");
        chk({31'h0, slv_q}, 32'h0, "mapped");
        apb(1'b0, `AMRS_OFF_TIMING, 32'h0);
        chk(rd_q, 32'h11111, "timing reset");
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, slv_q}, 32'h1, "unmapped");
        $display("test registers done");
        // two timing sets, expectations taken from the fields
        for (int i = 0; i < 2; i++) begin
            tim = i ? 32'h52413 : 32'h14121;
            rd_cycle(i ? 24'h00BEEF : 24'h123456);
            chk(t[1] - t[0], tim[3:0], "setup");
            chk(t[2] - t[1], tim[7:4], "valid");
            chk(t[3] - t[2], tim[11:8], "post");
            chk(t[4] - t[3], tim[15:12], "access");
            chk(t[5] - t[4], tim[19:16], "hold");
            chk(t[3] - t[6], tim[7:4] + tim[11:8], "oe lead");
            chk(t[3] - t[0], tim[3:0] + tim[7:4] + tim[11:8], "addr lead");
            chk({26'h0, bs_q, be_q}, 32'h2E, "selects");
        end
        $display("test read timing done");
        // every other bank mode refuses the start
        k = t[0];
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, `AMRS_OFF_CTRL, m);
            apb(1'b1, `AMRS_OFF_CMD, 32'h100);
            apb(1'b0, `AMRS_OFF_STATUS, 32'h0);
            chk(rd_q & 32'h5, 32'h4, "refused");
            apb(1'b1, `AMRS_OFF_STATUS, 32'h4);
        end
        chk(t[0], k, "no cycle");
        $display("test mode refusal done");
        // ready waiting with bus clock on the pin
        ready_delay <= 8'h08;
        tim = 32'h12121;
        apb(1'b1, `AMRS_OFF_CTRL, 32'h1C);
        rd_cycle(24'h00A0F0);
        chk(t[4] - t[7] <= 3, 1, "ready to strobe");
        chk(t[4] - t[3] > 8, 1, "extended");
        @(posedge sys_clk);
        #1;
        chk(clk_pin, 1, "pin high");
        @(negedge sys_clk);
        #1;
        chk(clk_pin, 0, "pin low");
        apb(1'b1, `AMRS_OFF_CTRL, 32'h0);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(clk_pin, 0, "pin off");
        $display("test ready and clock done");
        stop_test();
    end
endmodule
`default_nettype wire
